// [asp_pkg.sv]
// Summary of operation
// - set-position loads a new signed 32-bit position, no pulses, no motion
// - set-position is allowed only while the axis stands still
// - each command starts on execute rising edge, sampling its parameters then
// - execute falling clears results once execution has terminated
// - set-position coordinate defaults to zero
// - a fault sets error, ends execution, code shown only while error is set
// - stop enters stopping, aborts the running move and clears the queue
// - while stopping, motion requests from other commands are refused
// - stop from standstill goes to stopping and back when execute drops
// - stopping is held while stop execute stays high, even at zero speed, unless a fault has ended the stop
// - stop done only when the ramp has ended and velocity is zero
// - stop deceleration of zero selects the fast-stop deceleration
// - deceleration is Hz/ms or ms by mode, default 20, duration capped 100000 ms
// - jerk percent 0 to 100, default 0, shapes a rate-mode stop into an S-curve; time mode ignores it
// - a completed stop leaves output frequency at zero
// - stop reports aborted and finishes when a fault preempts it
// - stop busy stays high until complete, aborted or faulted
// - done means error-free; done and error never together
package asp_pkg;

  // timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int MS_NS         = 1000000;
  localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL       = 8'h00;
  localparam logic [7:0] OFS_SP_POS     = 8'h04;
  localparam logic [7:0] OFS_DECEL      = 8'h08;
  localparam logic [7:0] OFS_JERK       = 8'h0c;
  localparam logic [7:0] OFS_FAST_DECEL = 8'h10;
  localparam logic [7:0] OFS_POSITION   = 8'h14;
  localparam logic [7:0] OFS_STATUS     = 8'h18;
  localparam logic [7:0] OFS_FAULT      = 8'h1c;

  // control bits
  localparam int CTRL_SP_EXEC   = 0;
  localparam int CTRL_ST_EXEC   = 1;
  localparam int CTRL_TIME_MODE = 2;
  localparam int CTRL_W         = 3;

  // status bits
  localparam int STS_SP_DONE  = 0;
  localparam int STS_SP_ERR   = 1;
  localparam int STS_ST_DONE  = 2;
  localparam int STS_ST_BUSY  = 3;
  localparam int STS_ST_ABORT = 4;
  localparam int STS_ST_ERR   = 5;
  localparam int STS_STOPPING = 6;

  // fault register fields
  localparam int FLT_SP_LSB = 0;
  localparam int FLT_ST_LSB = 8;

  // reset values and limits
  localparam logic [31:0] SP_POS_RST     = 32'h0000_0000;
  localparam logic [31:0] DECEL_RST      = 32'h0000_0014;
  localparam logic [15:0] JERK_RST       = 16'h0000;
  localparam logic [31:0] FAST_DECEL_RST = 32'h0000_03e8;
  localparam logic [31:0] DUR_MAX_MS     = 32'h0001_86a0;
  localparam logic [7:0]  JERK_MAX       = 8'h64;

  typedef enum logic [7:0] {
    FC_NONE      = 8'h00,
    FC_NOT_STILL = 8'h01,
    FC_AXIS_FLT  = 8'h02
  } asp_fault_code_t;

  typedef enum logic [3:0] {
    SC_IDLE = 4'b0001,
    SC_RAMP = 4'b0010,
    SC_HOLD = 4'b0100,
    SC_END  = 4'b1000
  } asp_stop_st_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } asp_bus_req_t;

  typedef struct packed {
    logic [31:0] freq;
    logic        moving;
    logic        step;
    logic        step_dir;
    logic        move_req;
    logic        fault;
  } asp_axis_in_t;

  typedef struct packed {
    logic [31:0] freq;
    logic        stopping;
    logic        abort_move;
    logic        queue_clear;
    logic        move_refused;
  } asp_axis_out_t;

endpackage

// [asp_axis_stop.sv]
`timescale 1ns/1ps
module asp_axis_stop
  import asp_pkg::*;
#(
  parameter int MS_CYC = MS_CYCLES
)(
  input  wire logic          clk,
  input  wire logic          srst,
  input  wire asp_bus_req_t  bus,
  output logic [31:0]        rdata,
  input  wire asp_axis_in_t  axis_in,
  output asp_axis_out_t      axis_out
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [31:0] pct_of(input logic [31:0] x, input logic [7:0] p);
    logic [39:0] prod;
    prod = x * p;
    return prod[31:0] == 32'h0 && prod == 40'h0 ? 32'h0 : 32'(prod / 40'd100);
  endfunction

  function automatic logic [7:0] jerk_clamp(input logic [15:0] j);
    return (j > {8'h00, JERK_MAX}) ? JERK_MAX : j[7:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state declarations
  logic [CTRL_W-1:0] ctrl_q;
  logic [31:0]       sp_pos_q;
  logic [31:0]       decel_q;
  logic [15:0]       jerk_q;
  logic [31:0]       fast_q;
  logic [31:0]       pos_q;
  logic [1:0]        exec_prev_q;
  logic              sp_done_q;
  logic              sp_err_q;
  asp_fault_code_t   sp_code_q;
  asp_stop_st_t      st_q;
  logic              st_done_q;
  logic              st_abort_q;
  logic              st_err_q;
  asp_fault_code_t   st_code_q;
  logic [31:0]       freq_q;
  logic [31:0]       freq0_q;
  logic [31:0]       rate_q;
  logic [31:0]       rate_full_q;
  logic [31:0]       rate_inc_q;
  logic [31:0]       dur_q;
  logic [32:0]       acc_q;
  logic              time_mode_q;
  logic [31:0]       ms_cnt_q;
  logic [31:0]       out_freq_q;
  logic              pulse_q;
  logic              sp_rise;
  logic              st_rise;
  logic              stopping;
  logic              ms_tick;
  logic              sp_ok;
  logic [31:0]       eff_decel;
  logic [7:0]        jerk_eff;
  logic [32:0]       acc_add;

  ////////////////////////////////////////////////////////////////////////////
  // command edges and decode
  assign sp_rise   = ctrl_q[CTRL_SP_EXEC] & ~exec_prev_q[0];
  assign st_rise   = ctrl_q[CTRL_ST_EXEC] & ~exec_prev_q[1];
  assign stopping  = (st_q == SC_RAMP) | (st_q == SC_HOLD);
  assign sp_ok     = ~stopping & ~axis_in.moving;
  assign ms_tick   = (ms_cnt_q == 32'(MS_CYC - 1));
  assign eff_decel = (decel_q == 32'h0) ? fast_q : decel_q;
  assign jerk_eff  = jerk_clamp(jerk_q);

  // edge memory of both execute bits
  always_ff @(posedge clk) begin
    if (srst) begin
      exec_prev_q <= 2'b00;
    end else begin
      exec_prev_q <= {ctrl_q[CTRL_ST_EXEC], ctrl_q[CTRL_SP_EXEC]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software registers
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_q   <= '0;
      sp_pos_q <= SP_POS_RST;
      decel_q  <= DECEL_RST;
      jerk_q   <= JERK_RST;
      fast_q   <= FAST_DECEL_RST;
    end else if (bus.wr) begin
      case (bus.addr)
        OFS_CTRL:       ctrl_q   <= bus.wdata[CTRL_W-1:0];
        OFS_SP_POS:     sp_pos_q <= bus.wdata;
        OFS_DECEL:      decel_q  <= bus.wdata;
        OFS_JERK:       jerk_q   <= bus.wdata[15:0];
        OFS_FAST_DECEL: fast_q   <= bus.wdata;
        default:        ctrl_q   <= ctrl_q;
      endcase
    end
  end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge clk) begin
    if (srst || !bus.rd) begin
      rdata <= 32'h0;
    end else begin
      case (bus.addr)
        OFS_CTRL:       rdata <= {{(32-CTRL_W){1'b0}}, ctrl_q};
        OFS_SP_POS:     rdata <= sp_pos_q;
        OFS_DECEL:      rdata <= decel_q;
        OFS_JERK:       rdata <= {16'h0, jerk_q};
        OFS_FAST_DECEL: rdata <= fast_q;
        OFS_POSITION:   rdata <= pos_q;
        OFS_STATUS:     rdata <= {25'h0, stopping, st_err_q, st_abort_q,
                                  (st_q == SC_RAMP), st_done_q, sp_err_q, sp_done_q};
        OFS_FAULT:      rdata <= {16'h0, st_code_q, sp_code_q};
        default:        rdata <= 32'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // set-position results; the command ends in its start cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      sp_done_q <= 1'b0;
      sp_err_q  <= 1'b0;
      sp_code_q <= FC_NONE;
    end else if (sp_rise) begin
      sp_done_q <= sp_ok;
      sp_err_q  <= ~sp_ok;
      sp_code_q <= sp_ok ? FC_NONE : FC_NOT_STILL;
    end else if (!ctrl_q[CTRL_SP_EXEC]) begin
      // if execute already fell, results show for a single cycle
      sp_done_q <= 1'b0;
      sp_err_q  <= 1'b0;
      sp_code_q <= FC_NONE;
    end
  end

  // absolute position counter; a load wins over a pulse step
  always_ff @(posedge clk) begin
    if (srst) begin
      pos_q <= 32'h0;
    end else if (sp_rise && sp_ok) begin
      pos_q <= sp_pos_q;
    end else if (axis_in.step) begin
      pos_q <= axis_in.step_dir ? pos_q - 32'h1 : pos_q + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stop sequencer
  always_ff @(posedge clk) begin
    if (srst) begin
      st_q       <= SC_IDLE;
      st_done_q  <= 1'b0;
      st_abort_q <= 1'b0;
      st_err_q   <= 1'b0;
      st_code_q  <= FC_NONE;
    end else begin
      case (st_q)
        SC_IDLE: begin
          if (st_rise) begin
            st_q <= SC_RAMP;
          end
        end
        SC_RAMP: begin
          if (axis_in.fault) begin
            st_q       <= SC_END;
            st_abort_q <= 1'b1;
            st_err_q   <= 1'b1;
            st_code_q  <= FC_AXIS_FLT;
          end else if (freq_q == 32'h0) begin
            st_q      <= SC_HOLD;
            st_done_q <= 1'b1;
          end
        end
        SC_HOLD: begin
          // stays stopping while execute is held
          if (!ctrl_q[CTRL_ST_EXEC]) begin
            st_q      <= SC_IDLE;
            st_done_q <= 1'b0;
          end
        end
        SC_END: begin
          if (!ctrl_q[CTRL_ST_EXEC]) begin
            st_q       <= SC_IDLE;
            st_abort_q <= 1'b0;
            st_err_q   <= 1'b0;
            st_code_q  <= FC_NONE;
          end
        end
        default: begin
          st_q <= SC_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ramp parameters caught at the start edge
  always_ff @(posedge clk) begin
    if (srst) begin
      time_mode_q <= 1'b0;
      rate_q      <= 32'h0;
      rate_full_q <= 32'h0;
      rate_inc_q  <= 32'h0;
      dur_q       <= 32'h0;
      freq0_q     <= 32'h0;
    end else if (st_rise && st_q == SC_IDLE) begin
      time_mode_q <= ctrl_q[CTRL_TIME_MODE];
      freq0_q     <= axis_in.freq;
      dur_q       <= (eff_decel > DUR_MAX_MS) ? DUR_MAX_MS : eff_decel;
      rate_full_q <= eff_decel;
      // s-curve: start at a reduced rate and grow back to full
      rate_q      <= pct_of(eff_decel, JERK_MAX - jerk_eff);
      rate_inc_q  <= (pct_of(eff_decel, jerk_eff) == 32'h0) ? 32'h1
                                                            : pct_of(eff_decel, jerk_eff);
    end else if (st_q == SC_RAMP && ms_tick && !time_mode_q) begin
      rate_q <= (rate_q + rate_inc_q > rate_full_q) ? rate_full_q
                                                    : rate_q + rate_inc_q;
    end
  end

  // millisecond timebase, only runs while ramping
  always_ff @(posedge clk) begin
    if (srst || st_q != SC_RAMP) begin
      ms_cnt_q <= 32'h0;
    end else begin
      ms_cnt_q <= ms_tick ? 32'h0 : ms_cnt_q + 32'h1;
    end
  end

  // time mode spreads freq0 over dur ms, one hertz removed per cycle as owed;
  // the share is booked at the start of each ms so the ramp ends on time, and
  // at most one hertz goes per cycle, so freq0 / dur above MS_CYC runs late
  assign acc_add = (ms_cnt_q == 32'h0) ? {1'b0, freq0_q} : 33'h0;

  always_ff @(posedge clk) begin
    if (srst || st_q != SC_RAMP) begin
      acc_q <= 33'h0;
    end else if (acc_q >= {1'b0, dur_q}) begin
      acc_q <= acc_q - {1'b0, dur_q} + acc_add;
    end else begin
      acc_q <= acc_q + acc_add;
    end
  end

  // ramped frequency
  always_ff @(posedge clk) begin
    if (srst) begin
      freq_q <= 32'h0;
    end else if (st_rise && st_q == SC_IDLE) begin
      freq_q <= axis_in.freq;
    end else if (st_q == SC_RAMP) begin
      if (axis_in.fault) begin
        freq_q <= 32'h0;
      end else if (time_mode_q) begin
        if (dur_q == 32'h0) begin
          freq_q <= 32'h0;
        end else if (acc_q >= {1'b0, dur_q} && freq_q != 32'h0) begin
          freq_q <= freq_q - 32'h1;
        end
      end else if (ms_tick) begin
        freq_q <= (freq_q > rate_q) ? freq_q - rate_q : 32'h0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // axis-side outputs
  always_ff @(posedge clk) begin
    if (srst) begin
      out_freq_q <= 32'h0;
      pulse_q    <= 1'b0;
    end else begin
      // idle passes the move generator through; otherwise the ramp drives
      out_freq_q <= (st_q == SC_IDLE) ? axis_in.freq : freq_q;
      pulse_q    <= st_rise && st_q == SC_IDLE;
    end
  end

  assign axis_out.freq         = out_freq_q;
  assign axis_out.stopping     = stopping;
  assign axis_out.abort_move   = pulse_q;
  assign axis_out.queue_clear  = pulse_q;
  assign axis_out.move_refused = axis_in.move_req & stopping;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_stop_start;
    st_rise && st_q == SC_IDLE;
  endsequence

  sequence s_still_load;
    sp_rise && sp_ok;
  endsequence

  chk_sp_load_pos: assert property (s_still_load |=> pos_q == $past(sp_pos_q) && sp_done_q)
    else $error("position not loaded");
  chk_sp_refuse_move: assert property (sp_rise && !sp_ok |=> $stable(pos_q) && sp_err_q
    && sp_code_q == FC_NOT_STILL) else $error("set-position off standstill accepted");
  chk_sp_clear_low: assert property (!ctrl_q[CTRL_SP_EXEC] && !sp_rise |=> !sp_done_q
    && !sp_err_q) else $error("set-position result not cleared");
  chk_code_only_err: assert property ((st_code_q != FC_NONE) == st_err_q
    && (sp_code_q != FC_NONE) == sp_err_q) else $error("fault code without error");
  chk_stop_entry: assert property (s_stop_start |=> stopping && axis_out.abort_move
    && axis_out.queue_clear ##1 !axis_out.abort_move) else $error("stop entry wrong");
  chk_refuse_move: assert property (stopping && axis_in.move_req |-> axis_out.move_refused)
    else $error("move not refused");
  chk_hold_stopping: assert property (st_q == SC_HOLD && ctrl_q[CTRL_ST_EXEC] |=> stopping)
    else $error("stopping left while execute high");
  chk_done_zero: assert property (st_done_q |-> freq_q == 32'h0 && !st_err_q
    && !(st_q == SC_RAMP)) else $error("done with speed or error");
  chk_fast_decel: assert property (s_stop_start ##0 decel_q == 32'h0 && jerk_q == 16'h0
    |=> rate_q == $past(fast_q)) else $error("fast decel not used");
  chk_dur_cap: assert property (s_stop_start ##0 eff_decel > DUR_MAX_MS
    |=> dur_q == DUR_MAX_MS) else $error("duration not capped");
  chk_fault_abort: assert property (st_q == SC_RAMP && axis_in.fault |=> st_abort_q
    && st_err_q && st_q == SC_END && freq_q == 32'h0) else $error("fault did not abort stop");
  chk_back_idle: assert property (st_q == SC_HOLD && !ctrl_q[CTRL_ST_EXEC]
    |=> st_q == SC_IDLE && !st_done_q ##1 axis_out.freq == $past(axis_in.freq))
    else $error("no return to standstill");

  // stop pulse, busy span, held results and flags right after reset
  chk_abort_pulse: assert property (axis_out.abort_move |=> !axis_out.abort_move)
    else $error("abort pulse longer than one cycle");
  chk_busy_ramp: assert property (st_q == SC_RAMP && !axis_in.fault && freq_q != 32'h0
    |=> st_q == SC_RAMP) else $error("busy dropped before the ramp ended");
  chk_sp_exec_hold: assert property (sp_done_q && ctrl_q[CTRL_SP_EXEC] |=> sp_done_q)
    else $error("set-position done dropped while execute high");
  chk_hold_zero_freq: assert property (st_q == SC_HOLD |-> axis_out.freq == 32'h0)
    else $error("output frequency not zero in hold");
  chk_reset_flags: assert property ($fell(srst) |-> !sp_done_q && !sp_err_q
    && !st_done_q && !st_abort_q && !st_err_q && st_q == SC_IDLE)
    else $error("flags set after reset");

endmodule // asp_axis_stop

// [asp_axis_model.sv]
`timescale 1ns/1ps
// stands in for the move generator that sits beside the block
module asp_axis_model
  import asp_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          srst,
  input  wire logic [31:0]   freq_cmd,
  input  wire logic          moving_cmd,
  input  wire logic          fault_cmd,
  input  wire logic          req_cmd,
  input  wire logic [1:0]    step_cmd,
  input  wire asp_axis_out_t axis_out,
  output asp_axis_in_t       axis_in
);
  ////////////////////////////////////////////////////////////////////////////////
  // once stopping, the generator follows the block's ramp, as the real one does
  always_ff @(posedge clk) begin
    if (srst) begin
      axis_in <= '0;
    end else begin
      axis_in.freq     <= axis_out.stopping ? axis_out.freq : freq_cmd;
      axis_in.moving   <= axis_out.stopping ? (axis_out.freq != 32'h0) : moving_cmd;
      axis_in.step     <= step_cmd[0]; // pulses only when the bench asks for them
      axis_in.step_dir <= step_cmd[1];
      axis_in.move_req <= req_cmd;
      axis_in.fault    <= fault_cmd;
    end
  end
endmodule // asp_axis_model

// [asp_axis_stop_tb_top.sv]
`timescale 1ns/1ps
module asp_axis_stop_tb_top;
  import asp_pkg::*;
  localparam int MS    = 20;
  localparam int LIMIT = 20000;
  logic          clk        = 1'b0;
  logic          srst       = 1'b1;
  asp_bus_req_t  bus        = '0;
  logic [31:0]   rdata;
  asp_axis_in_t  axis_in;
  asp_axis_out_t axis_out;
  logic [31:0]   freq_cmd   = 32'h0;
  logic          moving_cmd = 1'b0;
  logic          fault_cmd  = 1'b0;
  logic          req_cmd    = 1'b0;
  logic [1:0]    step_cmd   = 2'b00;
  int            n_fail     = 0;
  int            cmp_count  = 0;
  int            cyc        = 0;
  int            seed       = 32'h1510f585;
  logic [31:0]   exp_pos;

  ////////////////////////////////////////////////////////////////////////////////
  // short millisecond so the ramps finish in at most 120 cycles
  asp_axis_stop #(.MS_CYC(MS)) asp_axis_stop_i (
    .clk      (clk),
    .srst     (srst),
    .bus      (bus),
    .rdata    (rdata),
    .axis_in  (axis_in),
    .axis_out (axis_out)
  );

  asp_axis_model asp_axis_model_i (
    .clk        (clk),
    .srst       (srst),
    .freq_cmd   (freq_cmd),
    .moving_cmd (moving_cmd),
    .fault_cmd  (fault_cmd),
    .req_cmd    (req_cmd),
    .step_cmd   (step_cmd),
    .axis_out   (axis_out),
    .axis_in    (axis_in)
  );

  always #10 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // a hang ends in the same report
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_fail++;
      print_verdict;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one idle edge after each write lets the command edge detector catch up
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus <= '0;
    @(posedge clk);
  endtask

  // read data stand only in the cycle after the strobe edge
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
    @(posedge clk);
    bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk);
    bus <= '0;
    #1;
    chk(rdata & m, e);
  endtask

  // stop from a given speed; n_ms comes from the ramp arithmetic of the chosen mode
  task automatic run_stop(input logic [31:0] f, input logic [31:0] dec, input logic [31:0] ctl,
                          input int n_ms);
    int t0;
    @(posedge clk);
    freq_cmd   <= f;
    moving_cmd <= (f != 32'h0);
    wr(OFS_DECEL, dec);
    wr(OFS_CTRL, ctl);
    #1;
    t0 = cyc;
    chk({29'h0, axis_out.stopping, axis_out.abort_move, axis_out.queue_clear}, 32'h7);
    @(posedge clk);
    req_cmd <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk({31'h0, axis_out.move_refused}, 32'h1);
    req_cmd <= 1'b0;
    rd(OFS_STATUS, (f != 32'h0) ? 32'h48 : 32'h44);
    // look after the edge so the output and cyc have settled
    while (axis_out.freq !== 32'h0 && cyc < LIMIT) begin
      @(posedge clk);
      #1;
    end
    chk(32'((cyc - t0 + MS / 2) / MS), 32'(n_ms));
    repeat (2) @(posedge clk);
    rd(OFS_STATUS, 32'h44);
    chk(axis_out.freq, 32'h0);
    freq_cmd   <= 32'h0;
    moving_cmd <= 1'b0;
    wr(OFS_CTRL, 32'h0);
    rd(OFS_STATUS, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    rd(OFS_STATUS, 32'h0);
    rd(OFS_FAULT, 32'h0);
    rd(OFS_SP_POS, SP_POS_RST);
    rd(OFS_DECEL, DECEL_RST);
    rd(8'h20, 32'h0);
    // overwrite the position at standstill
    exp_pos = $random(seed);
    wr(OFS_SP_POS, exp_pos);
    wr(OFS_CTRL, 32'h1);
    rd(OFS_STATUS, 32'h1);
    rd(OFS_POSITION, exp_pos);
    // pulses move the counter: three up, one down
    @(posedge clk);
    step_cmd <= 2'b01;
    repeat (3) @(posedge clk);
    step_cmd <= 2'b11;
    @(posedge clk);
    step_cmd <= 2'b00;
    exp_pos = exp_pos + 32'd2;
    rd(OFS_POSITION, exp_pos);
    wr(OFS_POSITION, ~exp_pos);
    rd(OFS_POSITION, exp_pos);
    wr(OFS_CTRL, 32'h0);
    rd(OFS_STATUS, 32'h0);
    // a second request while moving is refused
    @(posedge clk);
    freq_cmd   <= 32'd100;
    moving_cmd <= 1'b1;
    wr(OFS_SP_POS, $random(seed));
    wr(OFS_CTRL, 32'h1);
    rd(OFS_STATUS, 32'h2);
    rd(OFS_FAULT, 32'(FC_NOT_STILL));
    rd(OFS_POSITION, exp_pos);
    wr(OFS_CTRL, 32'h0);
    rd(OFS_FAULT, 32'h0);
    // rate ramps: default decel, fast-stop decel, and from standstill
    run_stop(32'd100, DECEL_RST, 32'h2, 5);
    run_stop(32'd2500, 32'h0, 32'h2, 3);
    run_stop(32'h0, DECEL_RST, 32'h2, 0);
    // s-curve at half jerk: start rate 10, growing by 10 per ms up to 20
    wr(OFS_JERK, 32'd50);
    run_stop(32'd100, DECEL_RST, 32'h2, 6);
    wr(OFS_JERK, 32'h0);
    // time mode: a 5 ms ramp, then a duration above the cap from standstill
    run_stop(32'd100, 32'd5, 32'h6, 5);
    run_stop(32'h0, 32'd200000, 32'h6, 0);
    // a fault in mid-ramp preempts the stop
    @(posedge clk);
    freq_cmd   <= 32'd1000;
    moving_cmd <= 1'b1;
    wr(OFS_DECEL, 32'h1);
    wr(OFS_CTRL, 32'h2);
    @(posedge clk);
    fault_cmd <= 1'b1;
    repeat (3) @(posedge clk);
    rd(OFS_STATUS, 32'h30, 32'h3f);
    rd(OFS_FAULT, 32'(FC_AXIS_FLT) << FLT_ST_LSB);
    chk(axis_out.freq, 32'h0);
    fault_cmd  <= 1'b0;
    freq_cmd   <= 32'h0;
    moving_cmd <= 1'b0;
    wr(OFS_CTRL, 32'h0);
    rd(OFS_STATUS, 32'h0);
    print_verdict;
  end
endmodule // asp_axis_stop_tb_top
